// ---- common/quad_uart_pkg.sv ----
package quad_uart_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_CHAN = 4;
    localparam int FIFO_DEPTH = 64;
    localparam int SYNC_STAGES = 2;

    // ****************************************
    // Register offsets inside one channel
    // ****************************************
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_IER = 3'h1;
    localparam logic [2:0] ADDR_ISR = 3'h2;
    localparam logic [2:0] ADDR_LCR = 3'h3;
    localparam logic [2:0] ADDR_MCR = 3'h4;
    localparam logic [2:0] ADDR_LSR = 3'h5;
    localparam logic [2:0] ADDR_MSR = 3'h6;
    localparam logic [2:0] ADDR_SPR = 3'h7;

    // ****************************************
    // Field positions and values
    // ****************************************
    localparam int LCR_DLAB = 7;
    localparam logic [7:0] LCR_EFR_KEY = 8'hbf;
    localparam int FCR_FIFO_EN = 0;
    localparam int FCR_TX_CLR = 2;
    localparam int FCR_BLOCK = 3;
    localparam int FCR_TX_TRIG = 4;
    localparam int FCR_RX_TRIG = 6;
    localparam int IER_TX_EMPTY = 1;
    localparam int MCR_IRQ_GATE = 3;
    localparam int MCR_XON_ANY = 5;
    localparam int MCR_DIV4 = 7;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] MSR_VALUE = 8'h00;
    localparam logic [3:0] ISR_NONE = 4'h1;
    localparam logic [3:0] ISR_TX_EMPTY = 4'h2;

    // ****************************************
    // FIFO trigger levels
    // ****************************************
    typedef logic [6:0] fill_t;
    localparam fill_t TX_TRIG_0 = 7'h08;
    localparam fill_t TX_TRIG_1 = 7'h10;
    localparam fill_t TX_TRIG_2 = 7'h20;
    localparam fill_t TX_TRIG_3 = 7'h38;
    localparam fill_t RX_TRIG_0 = 7'h08;
    localparam fill_t RX_TRIG_1 = 7'h10;
    localparam fill_t RX_TRIG_2 = 7'h38;
    localparam fill_t RX_TRIG_3 = 7'h3c;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int RESET_MIN_NS = 40;
    localparam logic [3:0] RESET_MIN_CYC =
        4'((RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic div4;
        logic xon_any;
        logic irq_gate;
        logic fifo_en;
        logic block_mode;
    } chan_cfg_s;

    typedef struct packed {
        logic bus_style;
        logic reset_pin;
        logic rd_n;
        logic wr_n;
        logic [3:0] sel_n;
        logic addr_hi;
        logic addr_lo;
        logic read_not_write;
        logic irq_mode;
        logic prescale;
        logic [2:0] reg_addr;
        logic [7:0] data;
    } host_pins_s;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_READ = 3'b010,
        BUS_WRITE = 3'b100
    } bus_state_e;

endpackage

// ---- hdl/quad_uart_host_port_select.sv ----
`timescale 1ns/10ps
module quad_uart_host_port_select #(
    parameter int FIFO_DEPTH = quad_uart_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic bus_style,
    input wire logic reset_pin,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic [2:0] reg_addr,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic read_not_write,
    input wire logic sel_chan_a_n,
    input wire logic sel_chan_b_n,
    input wire logic sel_chan_c_n,
    input wire logic sel_chan_d_n,
    input wire logic chan_addr_lo,
    input wire logic chan_addr_hi,
    input wire logic irq_mode_select,
    input wire logic prescale_default_select,
    input wire logic [3:0] tx_pop,
    input wire quad_uart_pkg::fill_t [3:0] rx_fill,
    output logic [3:0] tx_irq,
    output logic [3:0] tx_irq_oe,
    output logic [3:0] tx_room_n,
    output logic [3:0] rx_avail_n,
    output logic [7:0] all_chan_fifo_flags,
    output quad_uart_pkg::chan_cfg_s [3:0] chan_cfg,
    output logic serial_hold
);

    // ****************************************
    // Reset release
    // ****************************************
    logic rst_meta_reg, rst_n_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Data travels with the strobes so both arrive with equal delay
    quad_uart_pkg::host_pins_s pins_raw, pins_meta_reg, pins_reg;

    assign pins_raw.bus_style = bus_style;
    assign pins_raw.reset_pin = reset_pin;
    assign pins_raw.rd_n = read_strobe_n;
    assign pins_raw.wr_n = write_strobe_n;
    assign pins_raw.sel_n = {sel_chan_d_n, sel_chan_c_n,
        sel_chan_b_n, sel_chan_a_n};
    assign pins_raw.addr_hi = chan_addr_hi;
    assign pins_raw.addr_lo = chan_addr_lo;
    assign pins_raw.read_not_write = read_not_write;
    assign pins_raw.irq_mode = irq_mode_select;
    assign pins_raw.prescale = prescale_default_select;
    assign pins_raw.reg_addr = reg_addr;
    assign pins_raw.data = data_in;

    // Idle values keep strobes and selects inactive while reset settles
    localparam quad_uart_pkg::host_pins_s PINS_IDLE = '{
        bus_style: 1'b1,
        reset_pin: 1'b0,
        rd_n: 1'b1,
        wr_n: 1'b1,
        sel_n: 4'hf,
        addr_hi: 1'b0,
        addr_lo: 1'b0,
        read_not_write: 1'b1,
        irq_mode: 1'b0,
        prescale: 1'b1,
        reg_addr: 3'h0,
        data: 8'h00
    };

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pins_meta_reg <= PINS_IDLE;
            pins_reg <= PINS_IDLE;
        end else begin
            pins_meta_reg <= pins_raw;
            pins_reg <= pins_meta_reg;
        end
    end

    // ****************************************
    // Bus style and channel decode
    // ****************************************
    wire strobe_mode = pins_reg.bus_style;
    wire [3:0] sel_n = pins_reg.sel_n;
    wire [3:0] sel = ~sel_n;

    wire sel_single = sel_n == 4'he || sel_n == 4'hd ||
        sel_n == 4'hb || sel_n == 4'h7;
    wire sel_all = sel_n == 4'h0;
    // Other select patterns match no listed code and are treated as idle
    wire [3:0] strobe_mask = sel_single ? sel :
        (sel_all ? 4'hf : 4'h0);
    wire [1:0] strobe_idx = sel[1] ? 2'h1 : sel[2] ? 2'h2 :
        sel[3] ? 2'h3 : 2'h0;

    wire chip_sel = !sel_n[0];
    wire [1:0] line_idx = {pins_reg.addr_hi, pins_reg.addr_lo};
    wire [3:0] line_mask = chip_sel ? 4'h1 << line_idx : 4'h0;

    wire [3:0] chan_mask = strobe_mode ? strobe_mask : line_mask;
    wire [1:0] rd_idx = strobe_mode ? strobe_idx : line_idx;
    // A broadcast select must never be read back
    wire read_allowed = strobe_mode ? sel_single : chip_sel;

    wire rd_req = strobe_mode ? !pins_reg.rd_n :
        chip_sel && pins_reg.read_not_write;
    wire wr_req = strobe_mode ? !pins_reg.wr_n :
        chip_sel && !pins_reg.read_not_write;

    // ****************************************
    // Pin reset pulse filter
    // ****************************************
    logic [3:0] pin_rst_cnt_reg;
    logic [3:0] pin_rst_cnt_next;
    logic chan_init_reg;

    wire pin_rst_level = strobe_mode ? pins_reg.reset_pin :
        !pins_reg.reset_pin;
    // Pulses shorter than the minimum width are deliberately ignored
    wire pin_rst_done = pin_rst_cnt_reg == quad_uart_pkg::RESET_MIN_CYC;

    always_comb begin
        pin_rst_cnt_next = pin_rst_cnt_reg;
        if (!pin_rst_level) begin
            pin_rst_cnt_next = 4'h0;
        end else if (!pin_rst_done) begin
            pin_rst_cnt_next = pin_rst_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pin_rst_cnt_reg <= 4'h0;
        end else begin
            pin_rst_cnt_reg <= pin_rst_cnt_next;
        end
    end

    // ****************************************
    // Strap capture after release
    // ****************************************
    logic [1:0] settle_cnt_reg;
    localparam logic [1:0] SETTLE_DONE = 2'(quad_uart_pkg::SYNC_STAGES);
    wire settled = settle_cnt_reg > SETTLE_DONE;

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            settle_cnt_reg <= 2'h0;
        end else if (!settled) begin
            settle_cnt_reg <= settle_cnt_reg + 2'h1;
        end
    end

    // Channels reinitialise while the pin reset is held or pins settle
    wire chan_init = pin_rst_done || !settled;
    wire strap_div4 = !pins_reg.prescale;

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            chan_init_reg <= 1'b1;
        end else begin
            chan_init_reg <= chan_init;
        end
    end

    // ****************************************
    // Host access sequencer
    // ****************************************
    quad_uart_pkg::bus_state_e state_reg, state_next;
    logic [7:0] rd_data_reg;
    logic [7:0] chan_rd [4];

    wire start_wr = wr_req && chan_mask != 4'h0 && !chan_init;
    wire start_rd = rd_req && read_allowed && !wr_req && !chan_init;
    wire commit = state_reg == quad_uart_pkg::BUS_IDLE && start_wr;
    wire capture = state_reg == quad_uart_pkg::BUS_IDLE &&
        !start_wr && start_rd;
    wire [3:0] wr_pulse = commit ? chan_mask : 4'h0;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            quad_uart_pkg::BUS_IDLE: begin
                if (start_wr) begin
                    state_next = quad_uart_pkg::BUS_WRITE;
                end else if (start_rd) begin
                    state_next = quad_uart_pkg::BUS_READ;
                end
            end
            quad_uart_pkg::BUS_READ: begin
                if (!rd_req || chan_init) begin
                    state_next = quad_uart_pkg::BUS_IDLE;
                end
            end
            quad_uart_pkg::BUS_WRITE: begin
                if (!wr_req) begin
                    state_next = quad_uart_pkg::BUS_IDLE;
                end
            end
            default: state_next = quad_uart_pkg::BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= quad_uart_pkg::BUS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rd_data_reg <= 8'h00;
        end else if (capture) begin
            rd_data_reg <= chan_rd[rd_idx];
        end
    end

    assign data_out = rd_data_reg;
    assign data_oe = state_reg == quad_uart_pkg::BUS_READ;

    // ****************************************
    // Channel register sets
    // ****************************************
    logic [3:0] irq_raw, room_n, avail_n;
    quad_uart_pkg::chan_cfg_s [3:0] cfg;

    for (genvar i = 0; i < quad_uart_pkg::NUM_CHAN; i++) begin : g_chan
        uart_chan_regs #(
            .FIFO_DEPTH(FIFO_DEPTH)
        ) u_regs (
            .clk(clk),
            .rst_n(rst_n_reg),
            .init(chan_init),
            .strap_div4(strap_div4),
            .wr_en(wr_pulse[i]),
            .addr(pins_reg.reg_addr),
            .wr_data(pins_reg.data),
            .tx_pop(tx_pop[i] && !chan_init),
            .rx_fill(chan_init ? 7'h00 : rx_fill[i]),
            .rd_data(chan_rd[i]),
            .tx_irq_raw(irq_raw[i]),
            .tx_room_n(room_n[i]),
            .rx_avail_n(avail_n[i]),
            .cfg(cfg[i])
        );
    end

    // ****************************************
    // Interrupt drive and status outputs
    // ****************************************
    // In strobe mode without the select strap, software must open the gate per channel
    logic [3:0] irq_drive;
    always_comb begin
        for (int i = 0; i < quad_uart_pkg::NUM_CHAN; i++) begin
            irq_drive[i] = !strobe_mode || pins_reg.irq_mode ||
                cfg[i].irq_gate;
        end
    end

    logic [3:0] tx_irq_reg, tx_irq_oe_reg, room_n_reg, avail_n_reg;
    quad_uart_pkg::chan_cfg_s [3:0] cfg_reg;

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            tx_irq_reg <= 4'h0;
            tx_irq_oe_reg <= 4'h0;
            room_n_reg <= 4'hf;
            avail_n_reg <= 4'hf;
            cfg_reg <= '0;
        end else begin
            tx_irq_reg <= irq_raw & irq_drive;
            tx_irq_oe_reg <= irq_drive;
            room_n_reg <= room_n;
            avail_n_reg <= avail_n;
            cfg_reg <= cfg;
        end
    end

    assign tx_irq = tx_irq_reg;
    assign tx_irq_oe = tx_irq_oe_reg;
    assign tx_room_n = room_n_reg;
    assign rx_avail_n = avail_n_reg;
    assign all_chan_fifo_flags = {avail_n_reg, room_n_reg};
    assign chan_cfg = cfg_reg;
    assign serial_hold = chan_init_reg;

endmodule

// ---- hdl/uart_chan_regs.sv ----
`timescale 1ns/10ps
module uart_chan_regs #(
    parameter int FIFO_DEPTH = quad_uart_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic init,
    input wire logic strap_div4,
    input wire logic wr_en,
    input wire logic [2:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic tx_pop,
    input wire quad_uart_pkg::fill_t rx_fill,
    output logic [7:0] rd_data,
    output logic tx_irq_raw,
    output logic tx_room_n,
    output logic rx_avail_n,
    output quad_uart_pkg::chan_cfg_s cfg
);
    localparam quad_uart_pkg::fill_t DEPTH = 7'(FIFO_DEPTH);
    localparam quad_uart_pkg::fill_t ONE = 7'h01;

    logic [7:0] lcr_reg, ier_reg, fcr_reg, mcr_reg;
    logic [7:0] spr_reg, dll_reg, dlm_reg, efr_reg;
    quad_uart_pkg::fill_t tx_fill_reg, tx_fill_next;

    // ****************************************
    // Write decode
    // ****************************************
    wire dlab = lcr_reg[quad_uart_pkg::LCR_DLAB];
    wire efr_sel = lcr_reg == quad_uart_pkg::LCR_EFR_KEY;
    wire at_data = wr_en && addr == quad_uart_pkg::ADDR_DATA;
    wire at_ier = wr_en && addr == quad_uart_pkg::ADDR_IER;
    wire at_isr = wr_en && addr == quad_uart_pkg::ADDR_ISR;
    wire wr_thr = at_data && !dlab;
    wire wr_dll = at_data && dlab;
    wire wr_ier = at_ier && !dlab;
    wire wr_dlm = at_ier && dlab;
    wire wr_fcr = at_isr && !efr_sel;
    wire wr_efr = at_isr && efr_sel;
    wire wr_lcr = wr_en && addr == quad_uart_pkg::ADDR_LCR;
    wire wr_mcr = wr_en && addr == quad_uart_pkg::ADDR_MCR;
    wire wr_spr = wr_en && addr == quad_uart_pkg::ADDR_SPR;

    wire fifo_en = fcr_reg[quad_uart_pkg::FCR_FIFO_EN];
    wire block = fcr_reg[quad_uart_pkg::FCR_BLOCK];

    // ****************************************
    // Transmit fill tracking
    // ****************************************
    // Toggling the FIFO enable also flushes, so a stale count never leaks
    wire tx_clear = wr_fcr && (wr_data[quad_uart_pkg::FCR_TX_CLR] ||
        wr_data[quad_uart_pkg::FCR_FIFO_EN] != fifo_en);
    wire [6:0] tx_cap = fifo_en ? DEPTH : ONE;
    wire tx_push = wr_thr && tx_fill_reg < tx_cap;
    wire tx_drop = tx_pop && tx_fill_reg != 7'h00;

    always_comb begin
        tx_fill_next = tx_fill_reg;
        if (tx_clear) begin
            tx_fill_next = 7'h00;
        end else if (tx_push && !tx_drop) begin
            tx_fill_next = tx_fill_reg + ONE;
        end else if (tx_drop && !tx_push) begin
            tx_fill_next = tx_fill_reg - ONE;
        end
    end

    wire [1:0] tx_sel = fcr_reg[quad_uart_pkg::FCR_TX_TRIG +: 2];
    wire [1:0] rx_sel = fcr_reg[quad_uart_pkg::FCR_RX_TRIG +: 2];
    wire [6:0] tx_trig = tx_sel == 2'h0 ? quad_uart_pkg::TX_TRIG_0 :
        tx_sel == 2'h1 ? quad_uart_pkg::TX_TRIG_1 :
        tx_sel == 2'h2 ? quad_uart_pkg::TX_TRIG_2 : quad_uart_pkg::TX_TRIG_3;
    wire [6:0] rx_trig = rx_sel == 2'h0 ? quad_uart_pkg::RX_TRIG_0 :
        rx_sel == 2'h1 ? quad_uart_pkg::RX_TRIG_1 :
        rx_sel == 2'h2 ? quad_uart_pkg::RX_TRIG_2 : quad_uart_pkg::RX_TRIG_3;
    wire tx_empty = tx_fill_reg == 7'h00;

    assign tx_irq_raw = fifo_en ? tx_fill_reg <= tx_trig : tx_empty;
    assign tx_room_n = (fifo_en && block) ? tx_fill_reg == DEPTH : !tx_empty;
    assign rx_avail_n = (fifo_en && block) ? rx_fill < rx_trig :
        rx_fill == 7'h00;

    // ****************************************
    // Register state
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lcr_reg <= quad_uart_pkg::REG_RST;
            ier_reg <= quad_uart_pkg::REG_RST;
            fcr_reg <= quad_uart_pkg::REG_RST;
            mcr_reg <= quad_uart_pkg::REG_RST;
            spr_reg <= quad_uart_pkg::REG_RST;
            dll_reg <= quad_uart_pkg::REG_RST;
            dlm_reg <= quad_uart_pkg::REG_RST;
            efr_reg <= quad_uart_pkg::REG_RST;
            tx_fill_reg <= 7'h00;
        end else if (init) begin
            lcr_reg <= quad_uart_pkg::REG_RST;
            ier_reg <= quad_uart_pkg::REG_RST;
            fcr_reg <= quad_uart_pkg::REG_RST;
            mcr_reg <= quad_uart_pkg::REG_RST;
            mcr_reg[quad_uart_pkg::MCR_DIV4] <= strap_div4;
            spr_reg <= quad_uart_pkg::REG_RST;
            dll_reg <= quad_uart_pkg::REG_RST;
            dlm_reg <= quad_uart_pkg::REG_RST;
            efr_reg <= quad_uart_pkg::REG_RST;
            tx_fill_reg <= 7'h00;
        end else begin
            if (wr_lcr) lcr_reg <= wr_data;
            if (wr_ier) ier_reg <= wr_data;
            if (wr_fcr) fcr_reg <= wr_data & 8'hf9;
            if (wr_mcr) mcr_reg <= wr_data;
            if (wr_spr) spr_reg <= wr_data;
            if (wr_dll) dll_reg <= wr_data;
            if (wr_dlm) dlm_reg <= wr_data;
            if (wr_efr) efr_reg <= wr_data;
            tx_fill_reg <= tx_fill_next;
        end
    end

    // ****************************************
    // Read selection
    // ****************************************
    wire tx_pend = tx_irq_raw && ier_reg[quad_uart_pkg::IER_TX_EMPTY];
    wire [7:0] isr_val = {{2{fifo_en}}, 2'b00,
        tx_pend ? quad_uart_pkg::ISR_TX_EMPTY : quad_uart_pkg::ISR_NONE};
    wire [7:0] lsr_val = {1'b0, tx_empty, !tx_room_n, 4'h0,
        rx_fill != 7'h00};

    always_comb begin
        unique case (addr)
            quad_uart_pkg::ADDR_DATA: rd_data = dlab ? dll_reg : 8'h00;
            quad_uart_pkg::ADDR_IER: rd_data = dlab ? dlm_reg : ier_reg;
            quad_uart_pkg::ADDR_ISR: rd_data = efr_sel ? efr_reg : isr_val;
            quad_uart_pkg::ADDR_LCR: rd_data = lcr_reg;
            quad_uart_pkg::ADDR_MCR: rd_data = mcr_reg;
            quad_uart_pkg::ADDR_LSR: rd_data = lsr_val;
            quad_uart_pkg::ADDR_MSR: rd_data = quad_uart_pkg::MSR_VALUE;
            quad_uart_pkg::ADDR_SPR: rd_data = spr_reg;
        endcase
    end

    assign cfg.div4 = mcr_reg[quad_uart_pkg::MCR_DIV4];
    assign cfg.xon_any = mcr_reg[quad_uart_pkg::MCR_XON_ANY];
    assign cfg.irq_gate = mcr_reg[quad_uart_pkg::MCR_IRQ_GATE];
    assign cfg.fifo_en = fifo_en;
    assign cfg.block_mode = block;

endmodule

// ---- verif/host_cpu_model.sv ----
`timescale 1ns/10ps
module host_cpu_model (
    input wire logic clk,
    input wire logic style,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    output logic [7:0] data_bus,
    output logic [2:0] addr,
    output logic rd_n,
    output logic wr_n,
    output logic rnw,
    output logic [3:0] sel_n,
    output logic [1:0] chan
);
    logic [7:0] wdata = 8'h00;
    logic drive = 1'b0;
    // Released bus shows the inverse of the last access data (ff on reads), never a stale copy
    assign data_bus = data_oe ? data_out : (drive ? wdata : ~wdata);
    initial begin
        {addr, rd_n, wr_n, rnw, sel_n, chan} = {3'h0, 3'b110, 4'hf, 2'h3};
    end
    // Strobe style ignores the channel bits, so they are left at 3 there
    task automatic acc(input logic rd, input logic [3:0] sel,
        input logic [1:0] ch, input logic [2:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(negedge clk);
        {addr, wdata, drive, chan} = {a, d, !rd, style ? 2'h3 : ch};
        if (style) {sel_n, rd_n, wr_n} = {sel, !rd, rd};
        else {sel_n, rnw} = {4'he, rd};
        repeat (6) @(negedge clk);
        q = data_oe ? data_bus : 8'hxx;
        {sel_n, rd_n, wr_n, drive} = {4'hf, 3'b110};
        repeat (6) @(negedge clk);
    endtask
endmodule

// ---- verif/host_port_sva.sv ----
`timescale 1ns/10ps
module host_port_sva (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic bus_style,
    input wire logic reset_pin,
    input wire logic read_strobe_n,
    input wire logic sel_chan_a_n,
    input wire logic sel_chan_b_n,
    input wire logic sel_chan_c_n,
    input wire logic sel_chan_d_n,
    input wire logic irq_mode_select,
    input wire logic prescale_default_select,
    input wire logic data_oe,
    input wire logic [3:0] tx_irq_oe,
    input wire logic [3:0] tx_room_n,
    input wire logic [3:0] rx_avail_n,
    input wire logic [7:0] all_chan_fifo_flags,
    input wire quad_uart_pkg::chan_cfg_s [3:0] chan_cfg,
    input wire logic serial_hold
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic [3:0] sel_n = {sel_chan_d_n, sel_chan_c_n, sel_chan_b_n,
        sel_chan_a_n};
    property p_oe_cause;
        $rose(data_oe) && bus_style |-> !$past(read_strobe_n, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("data bus driven without a read strobe");
    property p_no_bcast_read;
        (bus_style && sel_n == 4'h0)[*6] |-> !data_oe;
    endproperty
    a_no_bcast_read: assert property (p_no_bcast_read)
        else $error("data bus driven with all channels selected");
    property p_deselect;
        (sel_n == 4'hf)[*6] |-> !data_oe;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("data bus driven while deselected");
    property p_oe_release;
        (bus_style && read_strobe_n)[*5] |-> !data_oe;
    endproperty
    a_oe_release: assert property (p_oe_release)
        else $error("data bus still driven after read strobe");
    property p_pin_reset;
        (bus_style && reset_pin)[*8] |=> serial_hold;
    endproperty
    a_pin_reset: assert property (p_pin_reset)
        else $error("serial lines not held during pin reset");
    property p_irq_drive;
        (irq_mode_select && !serial_hold)[*4] |-> tx_irq_oe == 4'hf;
    endproperty
    a_irq_drive: assert property (p_irq_drive)
        else $error("interrupt pins not driven in continuous mode");
    property p_flag_mirror;
        ($stable(tx_room_n) && $stable(rx_avail_n))[*2]
            |-> all_chan_fifo_flags == {rx_avail_n, tx_room_n};
    endproperty
    a_flag_mirror: assert property (p_flag_mirror)
        else $error("shared flag byte differs from ready flags");
    property p_strap_hold;
        $changed(prescale_default_select) && !serial_hold
            |=> $stable(chan_cfg[0].div4)[*3];
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("prescaler follows strap outside reset");
    c_read: cover property ($rose(data_oe));
    c_bcast: cover property (bus_style && sel_n == 4'h0);
    c_init: cover property ($rose(serial_hold));
endmodule

// ---- verif/tb_quad_uart_host_port_select.sv ----
`timescale 1ns/10ps
bind quad_uart_host_port_select host_port_sva chk_u (.clk, .reset_n,
    .bus_style, .reset_pin, .read_strobe_n, .sel_chan_a_n, .sel_chan_b_n,
    .sel_chan_c_n, .sel_chan_d_n, .irq_mode_select, .prescale_default_select,
    .data_oe, .tx_irq_oe, .tx_room_n, .rx_avail_n, .all_chan_fifo_flags,
    .chan_cfg, .serial_hold);
module tb_quad_uart_host_port_select;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic bus_style = 1'b1;
    logic reset_pin = 1'b0;
    logic strap = 1'b0;
    logic irq_sel = 1'b1;
    logic [3:0] tx_pop = 4'h0;
    quad_uart_pkg::fill_t [3:0] rx_fill = '0;
    quad_uart_pkg::chan_cfg_s [3:0] cfg;
    logic [7:0] bus, dout, rv, flags;
    logic [2:0] addr;
    logic [3:0] sel_n, irq;
    logic [1:0] chan;
    logic oe, rd_n, wr_n, rnw;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    host_cpu_model cpu_u (.clk, .style(bus_style), .data_out(dout),
        .data_oe(oe), .data_bus(bus), .addr, .rd_n, .wr_n, .rnw, .sel_n,
        .chan);
    quad_uart_host_port_select dut_u (.clk, .reset_n, .bus_style, .reset_pin,
        .data_in(bus), .data_out(dout), .data_oe(oe), .reg_addr(addr),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .read_not_write(rnw),
        .sel_chan_a_n(sel_n[0]), .sel_chan_b_n(sel_n[1]),
        .sel_chan_c_n(sel_n[2]), .sel_chan_d_n(sel_n[3]),
        .chan_addr_lo(chan[0]), .chan_addr_hi(chan[1]),
        .irq_mode_select(irq_sel), .prescale_default_select(strap), .tx_pop,
        .rx_fill, .tx_irq(irq), .tx_irq_oe(), .tx_room_n(), .rx_avail_n(),
        .all_chan_fifo_flags(flags), .chan_cfg(cfg), .serial_hold());
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (miscompares == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [3:0] s, input logic [1:0] c,
        input logic [2:0] a, input logic [7:0] d);
        cpu_u.acc(1'b0, s, c, a, d, rv);
    endtask
    task automatic rd(input logic [3:0] s, input logic [1:0] c,
        input logic [2:0] a, input logic [7:0] exp);
        cpu_u.acc(1'b1, s, c, a, 8'h00, rv);
        chk(rv, exp);
    endtask
    task automatic pop;
        @(negedge clk) tx_pop = 4'h1;
        @(negedge clk) tx_pop = 4'h0;
        repeat (3) @(negedge clk);
    endtask
    // Whole run is near 550 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            close_out();
        end
    end
    initial begin
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        repeat (10) @(negedge clk);
        chk({7'h0, cfg[0].div4}, 8'h01);
        rd(4'he, 2'h0, 3'h7, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(~(4'h1 << i), 2'h0, 3'h7, 8'h10 + 8'(i));
        end
        for (int i = 0; i < 4; i++) begin
            rd(~(4'h1 << i), 2'h0, 3'h7, 8'h10 + 8'(i));
        end
        rd(4'h0, 2'h0, 3'h7, 8'hxx);
        rd(4'hf, 2'h0, 3'h7, 8'hxx);
        wr(4'h0, 2'h0, 3'h7, 8'h5a);
        for (int i = 0; i < 4; i++) begin
            rd(~(4'h1 << i), 2'h0, 3'h7, 8'h5a);
        end
        strap = 1'b1;
        wr(4'hd, 2'h0, 3'h4, 8'h28);
        chk({3'h0, cfg[1]}, 8'h0c);
        chk({7'h0, cfg[0].div4}, 8'h01);
        chk({4'h0, irq}, 8'h0f);
        irq_sel = 1'b0;
        repeat (4) @(negedge clk);
        chk({4'h0, irq}, 8'h02);
        irq_sel = 1'b1;
        repeat (4) @(negedge clk);
        wr(4'he, 2'h0, 3'h0, 8'h41);
        chk({4'h0, irq}, 8'h0e);
        chk(flags, 8'hf1);
        pop();
        chk({4'h0, irq}, 8'h0f);
        wr(4'he, 2'h0, 3'h2, 8'h01);
        repeat (9) wr(4'he, 2'h0, 3'h0, 8'h33);
        chk({7'h0, irq[0]}, 8'h00);
        pop();
        chk({7'h0, irq[0]}, 8'h01);
        bus_style = 1'b0;
        reset_pin = 1'b1;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 4; i++) begin
            wr(4'he, 2'(i), 3'h7, 8'h20 + 8'(i));
        end
        for (int i = 0; i < 4; i++) begin
            rd(4'he, 2'(i), 3'h7, 8'h20 + 8'(i));
        end
        bus_style = 1'b1;
        reset_pin = 1'b0;
        repeat (4) @(negedge clk);
        rd(4'hb, 2'h0, 3'h7, 8'h22);
        reset_pin = 1'b1;
        repeat (10) @(negedge clk);
        reset_pin = 1'b0;
        repeat (8) @(negedge clk);
        rd(4'h7, 2'h0, 3'h7, 8'h00);
        chk({7'h0, cfg[0].div4}, 8'h00);
        close_out();
    end
endmodule
